/* File: src/sadc_top.sv */
// Sequencer, register file and threshold compare of the converter.
//
// Overview of operation
// - Eight-bit threshold register, read/write, zero at reset, compared with result high byte.
// - Sample selected input for fixed time, then hold until conversion ends.
// - First step sets bit 9, compares to half scale, keeps bit if input not below it.
// - Each later step sets next bit, keeps it if input not below tap.
// - After ten bits, copy approximation into result and raise done pulse.
// - Software trigger: enable starts conversion, repeating while enable stays set.
// - Software trigger: config write during conversion aborts and restarts it.
// - External trigger: after enable, wait for the selected pin edge.
// - Hardware trigger: after each select conversion or full scan sequence, wait again for a trigger.
// - Hardware trigger: trigger during conversion aborts and restarts it.
// - Hardware trigger: config write during conversion aborts, then waits for trigger.
// - Timer trigger: each timer event starts a conversion.
// - Select mode converts only the named channel, storing each result.
// - Scan mode converts channel 0 up to selected, done pulse each channel.
// - Scan abort restarts at channel 0; hardware waits after full sequence.
// - Compare disabled: done pulse at every conversion end.
// - Compare enabled: pulse only if high byte at least or below threshold.
// - Result register is overwritten at every conversion end regardless.
// - Compare applies to every result in select and scan modes.
// - Edge field: none, falling, rising, both edges.
// - Result word holds ten bits on top, zeros below; high byte upper eight.
// - Enabling with reference bit clear turns reference on until enable clears.
`timescale 1ns/1ps
module sadc_top #(
   parameter int SAMPLE_CYCLES = sadc_pkg::SAMPLE_CYCLES,
   parameter int STEP_CYCLES = sadc_pkg::STEP_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sadc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Trigger sources.
   input wire logic external_trigger_pin,
   input wire logic timer_trigger_event,
   // Analog front end.
   input wire logic cmp_ge,
   output logic [2:0] analog_channel_sel,
   output logic sample_hold_en,
   output logic [sadc_pkg::RES_W-1:0] tap_code,
   output logic ref_gen_active,
   // Conversion end request.
   output logic conversion_done_irq
);
   localparam int RW = sadc_pkg::RES_W;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] chan;
      logic [7:0] cmpm;
      logic [7:0] thr;
      logic [RW-1:0] result;
      sadc_pkg::sadc_seq_type seq;
      logic [2:0] cur_ch;
      logic trg_s1;
      logic trg_s2;
      logic trg_prev;
      logic irq;
      logic ref_act;
      logic [sadc_pkg::SETTLE_W-1:0] settle;
      logic [31:0] prdata;
   } sadc_state_type;

   sadc_state_type s;
   sadc_state_type next_s;

   sadc_sar_if #(.RES_W(RW)) sar_bus ();

   // Address decode of the current transfer.
   logic [sadc_pkg::ADDR_W-1:0] a_mode, a_chan, a_cmpm, a_thr, a_res, a_resh, a_stat;
   assign a_mode = {sadc_pkg::MODE_IDX[9:0], 2'b00};
   assign a_chan = {sadc_pkg::CHAN_IDX[9:0], 2'b00};
   assign a_cmpm = {sadc_pkg::CMPM_IDX[9:0], 2'b00};
   assign a_thr = {sadc_pkg::THR_IDX[9:0], 2'b00};
   assign a_res = {sadc_pkg::RES_IDX[9:0], 2'b00};
   assign a_resh = {sadc_pkg::RESH_IDX[9:0], 2'b00};
   assign a_stat = {sadc_pkg::STAT_IDX[9:0], 2'b00};

   logic mapped, wr, cfg_wr, trig, go, stop, cmp_pass, en, hw, scan, settled;
   logic [2:0] sel_ch, first_ch;
   logic [7:0] hi_byte;

   // Decode flags used by the sequencer and the bus answer.
   always_comb begin
      mapped = (paddr == a_mode) || (paddr == a_chan) || (paddr == a_cmpm) || (paddr == a_thr)
         || (paddr == a_res) || (paddr == a_resh) || (paddr == a_stat);
      wr = psel && penable && pwrite;
      cfg_wr = wr && ((paddr == a_mode) || (paddr == a_chan) || (paddr == a_cmpm)
         || (paddr == a_thr));
      hi_byte = sar_bus.result[RW-1:RW-8];
      if (!s.cmpm[sadc_pkg::CMP_EN_BIT]) begin
         cmp_pass = 1'b1;
      end else if (s.cmpm[sadc_pkg::CMP_DIR_BIT]) begin
         cmp_pass = (hi_byte < s.thr);
      end else begin
         cmp_pass = (hi_byte >= s.thr);
      end
   end

   // Trigger detection on the synchronised pin and the timer pulse.
   logic rise, fall, pin_ev;
   always_comb begin
      rise = s.trg_s2 && !s.trg_prev;
      fall = !s.trg_s2 && s.trg_prev;
      case (sadc_pkg::sadc_edge_type'(s.chan[sadc_pkg::CHAN_EDGE_LSB+:2]))
         sadc_pkg::EDGE_FALL: pin_ev = fall;
         sadc_pkg::EDGE_RISE: pin_ev = rise;
         sadc_pkg::EDGE_BOTH: pin_ev = rise || fall;
         default: pin_ev = 1'b0;
      endcase
      if (s.chan[sadc_pkg::CHAN_SRC_BIT]) begin
         trig = s.chan[sadc_pkg::CHAN_HW_BIT] && timer_trigger_event;
      end else begin
         trig = s.chan[sadc_pkg::CHAN_HW_BIT] && pin_ev;
      end
   end

   // Register writes, sequencer and read data in one next-state process.
   always_comb begin
      next_s = s;
      next_s.irq = 1'b0;
      go = 1'b0;
      stop = 1'b0;
      // Pin synchroniser; only the second stage feeds the edge logic.
      next_s.trg_s1 = external_trigger_pin;
      next_s.trg_s2 = s.trg_s1;
      next_s.trg_prev = s.trg_s2;
      // Configuration writes take effect at the access edge.
      if (wr) begin
         if (paddr == a_mode) begin
            next_s.mode = pwdata[7:0];
         end else if (paddr == a_chan) begin
            next_s.chan = pwdata[7:0];
         end else if (paddr == a_cmpm) begin
            next_s.cmpm = {pwdata[7:6], 6'h00};
         end else if (paddr == a_thr) begin
            next_s.thr = pwdata[7:0];
         end
      end
      en = next_s.mode[sadc_pkg::MODE_EN_BIT];
      hw = next_s.chan[sadc_pkg::CHAN_HW_BIT];
      scan = next_s.mode[sadc_pkg::MODE_SCAN_BIT];
      sel_ch = next_s.chan[sadc_pkg::CHAN_FIELD_LSB+:3];
      first_ch = scan ? 3'h0 : sel_ch;
      // Sequencer.
      if (!en) begin
         next_s.seq = sadc_pkg::S_OFF;
         stop = (s.seq == sadc_pkg::S_CONV);
      end else begin
         case (s.seq)
            sadc_pkg::S_OFF: begin
               if (hw) begin
                  next_s.seq = sadc_pkg::S_WAIT;
               end else begin
                  next_s.seq = sadc_pkg::S_CONV;
                  next_s.cur_ch = first_ch;
                  go = 1'b1;
               end
            end
            sadc_pkg::S_WAIT: begin
               if (!hw) begin
                  next_s.seq = sadc_pkg::S_CONV;
                  next_s.cur_ch = first_ch;
                  go = 1'b1;
               end else if (trig && !cfg_wr) begin
                  next_s.seq = sadc_pkg::S_CONV;
                  next_s.cur_ch = first_ch;
                  go = 1'b1;
               end
            end
            sadc_pkg::S_CONV: begin
               if (cfg_wr) begin
                  next_s.cur_ch = first_ch;
                  if (hw) begin
                     next_s.seq = sadc_pkg::S_WAIT;
                     stop = 1'b1;
                  end else begin
                     go = 1'b1;
                  end
               end else if (trig) begin
                  next_s.cur_ch = first_ch;
                  go = 1'b1;
               end else if (sar_bus.done) begin
                  next_s.result = sar_bus.result;
                  next_s.irq = cmp_pass;
                  if (scan && (s.cur_ch < sel_ch)) begin
                     next_s.cur_ch = s.cur_ch + 3'h1;
                     go = 1'b1;
                  end else if (hw) begin
                     next_s.seq = sadc_pkg::S_WAIT;
                  end else begin
                     next_s.cur_ch = first_ch;
                     go = 1'b1;
                  end
               end
            end
            default: begin
               next_s.seq = sadc_pkg::S_OFF;
            end
         endcase
      end
      // Reference generator follows its bit or the enable bit.
      next_s.ref_act = next_s.mode[sadc_pkg::MODE_REF_BIT] || en;
      if (!s.ref_act) begin
         next_s.settle = '0;
      end else if (s.settle != '1) begin
         next_s.settle = s.settle + sadc_pkg::SETTLE_W'(1);
      end
      // Read data is captured in the setup cycle.
      if (psel && !penable && !pwrite) begin
         if (paddr == a_mode) begin
            next_s.prdata = {24'h0, s.mode};
         end else if (paddr == a_chan) begin
            next_s.prdata = {24'h0, s.chan};
         end else if (paddr == a_cmpm) begin
            next_s.prdata = {24'h0, s.cmpm};
         end else if (paddr == a_thr) begin
            next_s.prdata = {24'h0, s.thr};
         end else if (paddr == a_res) begin
            next_s.prdata = {16'h0, s.result, 6'h00};
         end else if (paddr == a_resh) begin
            next_s.prdata = {24'h0, s.result[RW-1:RW-8]};
         end else if (paddr == a_stat) begin
            next_s.prdata = {24'h0, sar_bus.busy, s.ref_act, settled, s.cur_ch, s.seq};
         end else begin
            next_s.prdata = 32'h0;
         end
      end
   end

   // Reference settle flag uses the speed mode bits to pick the wait.
   always_comb begin
      if (s.mode[sadc_pkg::MODE_SPEED_LSB+:2] != 2'b00) begin
         settled = (s.settle >= sadc_pkg::SETTLE_W'(sadc_pkg::REF_HS_CYC));
      end else begin
         settled = (s.settle >= sadc_pkg::SETTLE_W'(sadc_pkg::REF_NORM_CYC));
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Engine hookup.
   assign sar_bus.start = go;
   assign sar_bus.abort = stop;
   assign sar_bus.cmp = cmp_ge;

   sadc_engine #(
      .RES_W(RW),
      .SAMPLE_CYCLES(SAMPLE_CYCLES),
      .STEP_CYCLES(STEP_CYCLES)
   ) u_engine (
      .pclk(pclk),
      .presetn(presetn),
      .bus(sar_bus.eng)
   );

   // Outputs.
   assign prdata = s.prdata;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;
   assign analog_channel_sel = s.cur_ch;
   assign sample_hold_en = sar_bus.sample;
   assign tap_code = sar_bus.result;
   assign ref_gen_active = s.ref_act;
   assign conversion_done_irq = s.irq;

   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_thr_write;
      wr && (paddr == a_thr) |=> s.thr == $past(pwdata[7:0]);
   endproperty
   a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

   property p_done_copy;
      sar_bus.done && !cfg_wr && !trig && (s.seq == sadc_pkg::S_CONV) |=> s.result == $past(sar_bus.result);
   endproperty
   a_done_copy: assert property (p_done_copy) else $error("result not latched");

   property p_irq_plain;
      sar_bus.done && !cfg_wr && !trig && (s.seq == sadc_pkg::S_CONV) && !s.cmpm[7]
         |=> conversion_done_irq;
   endproperty
   a_irq_plain: assert property (p_irq_plain) else $error("done pulse missing");

   property p_irq_gated;
      sar_bus.done && s.cmpm[7] && !s.cmpm[6] && (hi_byte < s.thr) |=> !conversion_done_irq;
   endproperty
   a_irq_gated: assert property (p_irq_gated) else $error("pulse despite compare");

   property p_sw_restart;
      (s.seq == sadc_pkg::S_CONV) && cfg_wr && en && !hw |=> sample_hold_en && (s.cur_ch == $past(first_ch));
   endproperty
   a_sw_restart: assert property (p_sw_restart) else $error("no restart on write");

   property p_hw_wait;
      (s.seq == sadc_pkg::S_CONV) && cfg_wr && en && hw |=> (s.seq == sadc_pkg::S_WAIT) && !sar_bus.busy;
   endproperty
   a_hw_wait: assert property (p_hw_wait) else $error("no wait after write");

   property p_trig_restart;
      (s.seq == sadc_pkg::S_CONV) && trig && !cfg_wr && en |=> sample_hold_en ##1 sample_hold_en;
   endproperty
   a_trig_restart: assert property (p_trig_restart) else $error("trigger did not restart");

   property p_ref_auto;
      s.mode[sadc_pkg::MODE_EN_BIT] |-> ref_gen_active;
   endproperty
   a_ref_auto: assert property (p_ref_auto) else $error("reference off while enabled");

   property p_hw_idle;
      (s.seq == sadc_pkg::S_WAIT) && !trig && hw && en && !cfg_wr |=> !sar_bus.busy;
   endproperty
   a_hw_idle: assert property (p_hw_idle) else $error("conversion without trigger");

   c_scan_step: cover property (sar_bus.done && s.mode[6] && (s.cur_ch != 3'h0));
   c_hw_start: cover property ((s.seq == sadc_pkg::S_WAIT) ##1 (s.seq == sadc_pkg::S_CONV));
   c_gated: cover property (sar_bus.done && s.cmpm[7] && !cmp_pass);
   c_abort: cover property ((s.seq == sadc_pkg::S_CONV) && cfg_wr && hw);
endmodule

/* File: shared/sadc_pkg.sv */
// Shared constants and types for the converter sequencer.
package sadc_pkg;
   // Bus geometry.
   localparam int ADDR_W = 12;
   // Register indices; the byte address is four times the index.
   localparam logic [31:0] MODE_IDX = 32'hFFFFF200;
   localparam logic [31:0] CHAN_IDX = 32'hFFFFF201;
   localparam logic [31:0] CMPM_IDX = 32'hFFFFF202;
   localparam logic [31:0] THR_IDX = 32'hFFFFF203;
   localparam logic [31:0] RES_IDX = 32'hFFFFF204;
   localparam logic [31:0] RESH_IDX = 32'hFFFFF206;
   localparam logic [31:0] STAT_IDX = 32'hFFFFF207;
   // Reset values.
   localparam logic [7:0] REG_RST = 8'h00;
   // Mode register fields.
   localparam int MODE_EN_BIT = 7;
   localparam int MODE_SCAN_BIT = 6;
   localparam int MODE_TIME_LSB = 3;
   localparam int MODE_SPEED_LSB = 1;
   localparam int MODE_REF_BIT = 0;
   // Channel register fields.
   localparam int CHAN_EDGE_LSB = 6;
   localparam int CHAN_HW_BIT = 5;
   localparam int CHAN_SRC_BIT = 4;
   localparam int CHAN_FIELD_LSB = 0;
   // Compare mode register fields.
   localparam int CMP_EN_BIT = 7;
   localparam int CMP_DIR_BIT = 6;
   // Result layout.
   localparam int RES_W = 10;
   localparam int RES_SHIFT = 6;
   // Edge selection codes.
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00, EDGE_FALL = 2'b01, EDGE_RISE = 2'b10, EDGE_BOTH = 2'b11
   } sadc_edge_type;
   // Sequencer and engine states.
   typedef enum logic [1:0] {S_OFF = 2'b00, S_WAIT = 2'b01, S_CONV = 2'b10} sadc_seq_type;
   typedef enum logic [1:0] {E_IDLE = 2'b00, E_SAMPLE = 2'b01, E_STEP = 2'b10} sadc_eng_type;
   // Conversion timing defaults in clock cycles.
   localparam int SAMPLE_CYCLES = 16;
   localparam int STEP_CYCLES = 4;
   // Reference settle times and their cycle counts.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int REF_HS_US = 1;
   localparam int REF_NORM_US = 14;
   localparam int REF_HS_CYC = (REF_HS_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REF_NORM_CYC = (REF_NORM_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETTLE_W = 12;
endpackage

/* File: shared/sadc_sar_if.sv */
// Link between the sequencer and the approximation engine.
`timescale 1ns/1ps
interface sadc_sar_if #(parameter int RES_W = 10);
   logic start;
   logic abort;
   logic cmp;
   logic done;
   logic busy;
   logic sample;
   logic [RES_W-1:0] result;
   modport ctrl(output start, abort, cmp, input done, busy, sample, result);
   modport eng(input start, abort, cmp, output done, busy, sample, result);
endinterface

/* File: src/sadc_engine.sv */
// Sample, hold and bit-by-bit approximation engine.
`timescale 1ns/1ps
module sadc_engine #(
   parameter int RES_W = 10,
   parameter int SAMPLE_CYCLES = sadc_pkg::SAMPLE_CYCLES,
   parameter int STEP_CYCLES = sadc_pkg::STEP_CYCLES
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Sequencer link.
   sadc_sar_if.eng bus
);
   typedef struct packed {
      sadc_pkg::sadc_eng_type st;
      logic [7:0] cnt;
      logic [3:0] bitn;
      logic [RES_W-1:0] sar;
      logic done;
   } sadc_eng_state_type;

   sadc_eng_state_type s;
   sadc_eng_state_type next_s;

   // Next state: start restarts from sampling, abort returns to idle.
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (bus.start) begin
         next_s.st = sadc_pkg::E_SAMPLE;
         next_s.cnt = 8'h00;
         next_s.sar = '0;
      end else if (bus.abort) begin
         next_s.st = sadc_pkg::E_IDLE;
      end else begin
         case (s.st)
            sadc_pkg::E_SAMPLE: begin
               if (s.cnt == 8'(SAMPLE_CYCLES - 1)) begin
                  next_s.st = sadc_pkg::E_STEP;
                  next_s.cnt = 8'h00;
                  next_s.bitn = 4'(RES_W - 1);
                  next_s.sar[RES_W-1] = 1'b1;
               end else begin
                  next_s.cnt = s.cnt + 8'h01;
               end
            end
            sadc_pkg::E_STEP: begin
               if (s.cnt == 8'(STEP_CYCLES - 1)) begin
                  next_s.cnt = 8'h00;
                  if (!bus.cmp) begin
                     next_s.sar[s.bitn] = 1'b0;
                  end
                  if (s.bitn == 4'h0) begin
                     next_s.st = sadc_pkg::E_IDLE;
                     next_s.done = 1'b1;
                  end else begin
                     next_s.bitn = s.bitn - 4'h1;
                     next_s.sar[s.bitn-4'h1] = 1'b1;
                  end
               end else begin
                  next_s.cnt = s.cnt + 8'h01;
               end
            end
            default: begin
               next_s.st = sadc_pkg::E_IDLE;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Engine outputs; the trial word is also the tap code.
   assign bus.done = s.done;
   assign bus.busy = (s.st != sadc_pkg::E_IDLE);
   assign bus.sample = (s.st == sadc_pkg::E_SAMPLE);
   assign bus.result = s.sar;
endmodule

/* File: verif/sadc_afe_model.sv */
// Behavioural analog front end: channel levels and the comparator.
`timescale 1ns/1ps
module sadc_afe_model (
   // Converter side.
   input wire logic [2:0] channel_sel,
   input wire logic [9:0] tap_code,
   // Input levels as codes, one per channel.
   input wire logic [7:0][9:0] levels,
   // Comparator result.
   output logic cmp_ge
);
   // A tap equal to the held level keeps the trial bit, so a clean run returns the level itself.
   assign cmp_ge = levels[channel_sel] >= tap_code;
endmodule

/* File: verif/sadc_bench.sv */
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module sadc_bench;
   localparam int S = 2;
   localparam int T = 1;
   localparam int LAT = S + 10 * T + 2;
   localparam logic [11:0] A_MODE = 12'h800, A_CHAN = 12'h804, A_CMP = 12'h808, A_THR = 12'h80C;
   localparam logic [11:0] A_RES = 12'h810, A_RESH = 12'h818, A_BAD = 12'h814;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ext_pin = 1'b0, tmr = 1'b0, cmp_ge, sh_en, sh_d, ref_on, irq;
   logic [2:0] ch_sel;
   logic [9:0] tap;
   logic [7:0][9:0] vin = '0;
   logic [7:0] thr;
   logic [7:0] cm_t[3] = '{8'hC0, 8'h80, 8'h00};
   logic [31:0] rd_q[$];
   logic [2:0] ch_q[$];
   int miscompares = 0, compares = 0, irq_cnt = 0, c0 = 0, n0 = 0;

   // Free-running clock.
   always #2.5 pclk = ~pclk;

   sadc_top #(.SAMPLE_CYCLES(S), .STEP_CYCLES(T)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trigger_pin(ext_pin),
      .timer_trigger_event(tmr), .cmp_ge(cmp_ge), .analog_channel_sel(ch_sel), .sample_hold_en(sh_en),
      .tap_code(tap), .ref_gen_active(ref_on), .conversion_done_irq(irq));
   sadc_afe_model afe (.channel_sel(ch_sel), .tap_code(tap), .levels(vin), .cmp_ge(cmp_ge));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high at an edge.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask

   // Waits until n more done pulses arrive or the cycle limit runs out.
   task automatic wait_irq(input int n, input int lim);
      c0 = irq_cnt;
      for (int i = 0; i < lim && irq_cnt - c0 < n; i++) @(posedge pclk);
   endtask

   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watches the outputs and retires the oldest note of each kind as its result appears.
   always @(posedge pclk) begin
      sh_d <= sh_en;
      if (irq === 1'b1) irq_cnt++;
      if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) check("read", rd_q.pop_front(), prdata);
      if (sh_en === 1'b1 && sh_d !== 1'b1 && ch_q.size() > 0) check("channel", {29'h0, ch_q.pop_front()}, {29'h0, ch_sel});
      if (psel && penable && pready === 1'b1) check("slave error", {31'h0, paddr == A_BAD}, {31'h0, pslverr});
   end

   // Cuts a hang short.
   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      $display("watchdog expired");
      summarize();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'h2B45BEA8));
      for (int i = 0; i < 8; i++) vin[i] = 10'($urandom);
      thr = 8'($urandom);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_THR, 32'h0);
      bus(1'b1, A_THR, {24'h0, thr});
      rd(A_THR, {24'h0, thr});
      rd(A_BAD, 32'h0);
      $display("registers done");
      bus(1'b1, A_CHAN, 32'h3);
      bus(1'b1, A_MODE, 32'h80);
      @(negedge pclk) check("ref auto on", 1, ref_on);
      wait_irq(2, 3 * LAT);
      check("repeat count", 2, irq_cnt - c0);
      bus(1'b1, A_THR, 32'h0);
      wait_irq(1, LAT - 4);
      check("abort delay", 0, irq_cnt - c0);
      wait_irq(1, 2 * LAT);
      check("restart", 1, irq_cnt - c0);
      bus(1'b1, A_MODE, 32'h00);
      @(negedge pclk) check("ref auto off", 0, ref_on);
      rd(A_RES, {16'h0, vin[3], 6'h0});
      rd(A_RESH, {24'h0, vin[3][9:2]});
      $display("software select done");
      bus(1'b1, A_MODE, 32'h01);
      repeat (sadc_pkg::REF_NORM_CYC) @(posedge pclk);
      bus(1'b1, A_CHAN, 32'h5);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, A_CMP, {24'h0, cm_t[k]});
         bus(1'b1, A_THR, k == 2 ? 32'hFF : {24'h0, vin[5][9:2]});
         bus(1'b1, A_MODE, 32'h81);
         wait_irq(1, 3 * LAT);
         bus(1'b1, A_MODE, 32'h01);
         check("gated pulse", k == 0 ? 0 : 1, irq_cnt - c0);
         rd(A_RES, {16'h0, vin[5], 6'h0});
      end
      $display("compare done");
      bus(1'b1, A_CMP, 32'h0);
      for (int i = 0; i < 4; i++) ch_q.push_back(3'(i % 3));
      bus(1'b1, A_CHAN, 32'h2);
      bus(1'b1, A_MODE, 32'hC1);
      wait_irq(4, 6 * LAT);
      bus(1'b1, A_MODE, 32'h01);
      check("scan pulses", 4, irq_cnt - c0);
      check("scan order", 0, ch_q.size());
      vin[0] <= 10'h000;
      vin[1] <= 10'h3FF;
      vin[2] <= 10'h000;
      bus(1'b1, A_CMP, 32'h80);
      bus(1'b1, A_MODE, 32'hC1);
      wait_irq(2, 4 * LAT);
      check("scan gated", 1, irq_cnt - c0);
      ch_q.push_back(3'h0);
      bus(1'b1, A_THR, 32'hFF);
      bus(1'b1, A_MODE, 32'h01);
      check("scan restart", 0, ch_q.size());
      bus(1'b1, A_CMP, 32'h0);
      $display("scan done");
      for (int e = 0; e < 4; e++) begin
         bus(1'b1, A_CHAN, {24'h0, 2'(e), 6'h21});
         bus(1'b1, A_MODE, 32'h81);
         n0 = irq_cnt;
         ext_pin <= 1'b1;
         wait_irq(3, 2 * LAT);
         ext_pin <= 1'b0;
         wait_irq(3, 2 * LAT);
         check("edge pulses", e == 0 ? 0 : (e == 3 ? 2 : 1), irq_cnt - n0);
         bus(1'b1, A_MODE, 32'h01);
      end
      $display("external trigger done");
      bus(1'b1, A_CHAN, 32'h30);
      bus(1'b1, A_MODE, 32'h81);
      @(posedge pclk);
      tmr <= 1'b1;
      @(posedge pclk);
      tmr <= 1'b0;
      repeat (LAT / 2) @(posedge pclk);
      tmr <= 1'b1;
      @(posedge pclk);
      tmr <= 1'b0;
      wait_irq(1, LAT - 4);
      check("timer abort", 0, irq_cnt - c0);
      wait_irq(2, 3 * LAT);
      check("timer single", 1, irq_cnt - c0);
      tmr <= 1'b1;
      @(posedge pclk);
      tmr <= 1'b0;
      bus(1'b1, A_THR, 32'h0);
      wait_irq(1, 2 * LAT);
      check("timer write abort", 0, irq_cnt - c0);
      bus(1'b1, A_MODE, 32'h01);
      $display("timer trigger done");
      summarize();
   end
endmodule
